// ===== logic/smc_pkg.sv
// constants for the maintenance and device-information command logic
// assumes a separate i2c slave front end that decodes pointer and read-byte events
//
// Contract
// RULE1 - pointer 0x5607 with no data phase starts a manual fan cleaning cycle
// RULE2 - manual cleaning starts only in measuring state, ignored in any other state
// RULE3 - each identification string is at most 32 characters including the null
// RULE4 - pointer 0xD025 selects article code, 0xD033 serial number, then reads return it
// RULE5 - characters go out in ascending pairs, each pair then checksum, 48 bytes total
// RULE6 - software reset returns all state and settings to power-on values
// RULE7 - software reset is pointer 0xD304 with no write or read data phase
// RULE8 - cleaning drives fan at maximum for 10 seconds then back to normal
// RULE9 - measurement results are not updated while a cleaning cycle runs
// RULE10 - after power-up or software reset the device is idle, not measuring
// RULE11 - checksum byte is crc-8 over the two preceding data bytes
package smc_pkg;
	localparam logic [15:0] PTR_FAN_CLEAN = 16'h5607;
	localparam logic [15:0] PTR_ART_CODE = 16'hD025;
	localparam logic [15:0] PTR_SERIAL = 16'hD033;
	localparam logic [15:0] PTR_SOFT_RESET = 16'hD304;

	// string layout: character 0 in the top byte
	localparam int STR_CHARS = 32;
	localparam int STR_BITS = STR_CHARS * 8;
	localparam logic [4:0] STR_LAST_CHAR = 5'h1F;
	localparam logic [4:0] STR_PAIR_STEP = 5'h02;
	localparam logic [4:0] STR_FIRST_CHAR = 5'h00;
	localparam logic [4:0] STR_NEXT_CHAR = 5'h01;
	localparam logic [7:0] NULL_CHAR = 8'h00;
	localparam logic [7:0] IDLE_BYTE = 8'h00;

	// position of a byte inside a character pair group
	localparam logic [1:0] POS_CHAR_A = 2'h0;
	localparam logic [1:0] POS_CHAR_B = 2'h1;
	localparam logic [1:0] POS_CRC = 2'h2;

	// crc-8 of the pointer protocol
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hFF;

	// cleaning time
	localparam int CLK_HZ = 25_000_000;
	localparam int CLEAN_TIME_S = 10;
	localparam int CLEAN_CYCLES_DFLT = CLEAN_TIME_S * CLK_HZ;
	localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
	localparam logic [31:0] CNT_ONE = 32'h0000_0001;

	// identification strings: arbitrary neutral values
	localparam logic [STR_BITS-1:0] ART_CODE_DFLT = {"ART-0000-TEST", 152'h0};
	localparam logic [STR_BITS-1:0] SERIAL_DFLT = {"SN00000000000001", 128'h0};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MEAS = 3'b010,
		ST_CLEAN = 3'b100
	} smc_state_e;

	typedef enum logic [1:0] {
		SEL_NONE = 2'h0,
		SEL_ART = 2'h1,
		SEL_SER = 2'h2
	} smc_sel_e;
endpackage

// ===== logic/smc_crc8.sv
// crc-8 over two data bytes, purely combinational
// assumes msb-first processing, no final xor
`timescale 1ns/100ps
module smc_crc8
	import smc_pkg::*;
(
	// data
	input wire logic [7:0] i_byte_a,
	input wire logic [7:0] i_byte_b,
	// result
	output logic [7:0] o_crc
);
	import smc_pkg::*;

	always_comb
	begin
		logic [7:0] crc;
		logic [15:0] data;
		crc = CRC_INIT;
		data = {i_byte_a, i_byte_b};
		for (int i = 15; i >= 0; i--)
		begin
			if (crc[7] ^ data[i])
				crc = {crc[6:0], 1'b0} ^ CRC_POLY; // RULE11
			else
				crc = {crc[6:0], 1'b0};
		end
		o_crc = crc;
	end
endmodule

// ===== logic/smc_cmd.sv
// maintenance and device-information command interpreter
// assumes the i2c front end gives one strobe per pointer set and one per read byte,
// and decodes start/stop measurement itself, passing them as pulses
// cleaning time is counted in clocks, so CLEAN_CYCLES has to follow the clock rate
`timescale 1ns/100ps
module smc_cmd
	import smc_pkg::*;
#(
	parameter int unsigned CLEAN_CYCLES = CLEAN_CYCLES_DFLT,
	parameter logic [STR_BITS-1:0] ART_CODE = ART_CODE_DFLT,
	parameter logic [STR_BITS-1:0] SERIAL = SERIAL_DFLT
)
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// pointer set from the i2c front end
	input wire logic I_PTR_STROBE,
	input wire logic [15:0] I_PTR,
	input wire logic I_PTR_NODATA,
	// read byte request and answer
	input wire logic I_RD_REQ,
	output logic O_RD_VALID,
	output logic [7:0] O_RD_DATA,
	// measurement mode control from other decoders
	input wire logic I_MEAS_START,
	input wire logic I_MEAS_STOP,
	// device state
	output logic O_MEASURING,
	output logic O_FAN_MAX,
	output logic O_RESULT_HOLD,
	output logic O_SOFT_RESET
);
	import smc_pkg::*;

	typedef struct packed {
		smc_state_e st;
		logic [31:0] clean_cnt;
		smc_sel_e sel;
		logic [1:0] pos;
		logic [4:0] chr;
		logic str_done;
		logic rd_valid;
		logic [7:0] rd_data;
		logic meas_on;
		logic fan_max;
		logic hold;
		logic soft_rst;
	} smc_regs_s;

	localparam smc_regs_s REGS_RESET = '{
		st: ST_IDLE,
		clean_cnt: CNT_ZERO,
		sel: SEL_NONE,
		pos: POS_CHAR_A,
		chr: STR_FIRST_CHAR,
		str_done: 1'b0,
		rd_valid: 1'b0,
		rd_data: IDLE_BYTE,
		meas_on: 1'b0,
		fan_max: 1'b0,
		hold: 1'b0,
		soft_rst: 1'b0
	};
	localparam logic [31:0] CLEAN_LOAD = 32'(CLEAN_CYCLES);

	smc_regs_s r;
	smc_regs_s next_r;
	logic [7:0] char_a;
	logic [7:0] char_b;
	logic [7:0] pair_crc;
	logic [4:0] chr_b;

	// character fetch; the last slot is forced to null so the limit holds
	function automatic logic [7:0] get_char(input smc_sel_e sel, input logic [4:0] idx);
		logic [7:0] c;
		c = NULL_CHAR;
		if (sel == SEL_ART)
			c = ART_CODE[STR_BITS-1-8*idx -: 8]; // RULE4
		else if (sel == SEL_SER)
			c = SERIAL[STR_BITS-1-8*idx -: 8]; // RULE4
		if (idx == STR_LAST_CHAR)
			c = NULL_CHAR; // RULE3
		return c;
	endfunction

	assign chr_b = r.chr + STR_NEXT_CHAR;
	assign char_a = get_char(r.sel, r.chr);
	assign char_b = get_char(r.sel, chr_b);

	smc_crc8 u_crc
	(
		.i_byte_a(char_a),
		.i_byte_b(char_b),
		.o_crc(pair_crc)
	);

	always_comb
	begin
		logic cmd_clean;
		logic cmd_reset;
		cmd_clean = I_PTR_STROBE && I_PTR_NODATA && (I_PTR == PTR_FAN_CLEAN); // RULE1
		cmd_reset = I_PTR_STROBE && I_PTR_NODATA && (I_PTR == PTR_SOFT_RESET); // RULE7
		next_r = r;
		next_r.rd_valid = 1'b0;
		next_r.soft_rst = 1'b0;

		// measurement state
		case (r.st)
			ST_IDLE:
			begin
				// clean requests are dropped here: only measuring may clean
				if (I_MEAS_START)
					next_r.st = ST_MEAS;
			end
			ST_MEAS:
			begin
				if (I_MEAS_STOP)
					next_r.st = ST_IDLE;
				else if (cmd_clean)
				begin
					next_r.st = ST_CLEAN; // RULE2
					next_r.clean_cnt = CLEAN_LOAD;
				end
			end
			ST_CLEAN:
			begin
				// a second clean request is ignored, the cycle is not restarted
				// a stop aborts the cycle; the fan must not keep running in idle
				if (I_MEAS_STOP)
				begin
					next_r.st = ST_IDLE;
					next_r.clean_cnt = CNT_ZERO;
				end
				else if (r.clean_cnt <= CNT_ONE)
				begin
					next_r.st = ST_MEAS; // RULE8
					next_r.clean_cnt = CNT_ZERO;
				end
				else
					next_r.clean_cnt = r.clean_cnt - CNT_ONE; // RULE8
			end
			default:
				next_r.st = ST_IDLE;
		endcase

		// a read in the same cycle as a strobe is dropped and gets no answer
		// string selection restarts at character 0
		if (I_PTR_STROBE)
		begin
			next_r.pos = POS_CHAR_A;
			next_r.chr = STR_FIRST_CHAR;
			next_r.str_done = 1'b0;
			if (I_PTR == PTR_ART_CODE)
				next_r.sel = SEL_ART; // RULE4
			else if (I_PTR == PTR_SERIAL)
				next_r.sel = SEL_SER; // RULE4
			else
				next_r.sel = SEL_NONE;
		end
		else if (I_RD_REQ)
		begin
			next_r.rd_valid = 1'b1;
			next_r.rd_data = IDLE_BYTE;
			if ((r.sel != SEL_NONE) && !r.str_done)
			begin
				case (r.pos)
					POS_CHAR_A:
					begin
						next_r.rd_data = char_a; // RULE5
						next_r.pos = POS_CHAR_B;
					end
					POS_CHAR_B:
					begin
						next_r.rd_data = char_b; // RULE5
						next_r.pos = POS_CRC;
					end
					POS_CRC:
					begin
						next_r.rd_data = pair_crc; // RULE11
						next_r.pos = POS_CHAR_A;
						if (chr_b == STR_LAST_CHAR)
							next_r.str_done = 1'b1; // RULE5
						else
							next_r.chr = r.chr + STR_PAIR_STEP; // RULE5
					end
					default:
					begin
						// unused code: realign to a pair start rather than stall
						next_r.pos = POS_CHAR_A;
					end
				endcase
			end
		end

		next_r.meas_on = (next_r.st != ST_IDLE);
		next_r.fan_max = (next_r.st == ST_CLEAN); // RULE8
		next_r.hold = (next_r.st == ST_CLEAN); // RULE9

		// software reset wins over everything and restores power-on values
		if (cmd_reset)
		begin
			next_r = REGS_RESET; // RULE6 RULE10
			next_r.soft_rst = 1'b1; // RULE6
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			r <= REGS_RESET; // RULE10
		else
			r <= next_r;
	end

	assign O_RD_VALID = r.rd_valid;
	assign O_RD_DATA = r.rd_data;
	assign O_MEASURING = r.meas_on;
	assign O_FAN_MAX = r.fan_max;
	assign O_RESULT_HOLD = r.hold;
	assign O_SOFT_RESET = r.soft_rst;
endmodule

// ===== dv/smc_host.sv
// host model: pointer sets and byte reads
// assumes the device samples on the rising edge
`timescale 1ns/100ps
module smc_host (
	input wire logic i_clk, i_vld,
	input wire logic [7:0] i_data,
	output logic o_stb, o_nd, o_req,
	output logic [15:0] o_ptr
);
	initial {o_stb, o_nd, o_req, o_ptr} = '0;
	// released pointer shows the inverse, never the old value
	task set_ptr(input logic [15:0] p, input logic nd);
		@(negedge i_clk);
		{o_stb, o_ptr, o_nd} = {1'b1, p, nd};
		@(negedge i_clk);
		{o_stb, o_ptr, o_nd} = {1'b0, ~p, ~nd};
	endtask
	task rd(output logic [7:0] b, output logic v);
		@(negedge i_clk);
		o_req = 1;
		@(negedge i_clk);
		o_req = 0;
		{v, b} = {i_vld, i_data};
	endtask
endmodule

// ===== dv/smc_cmd_assertions.sv
// port checker for smc_cmd
// assumes one clock domain
`timescale 1ns/100ps
module smc_cmd_assertions #(parameter int unsigned CLEAN_CYCLES = 20)
(
	input wire logic I_CLK, I_RST_N, I_PTR_STROBE, I_PTR_NODATA, I_RD_REQ,
	input wire logic [15:0] I_PTR,
	input wire logic I_MEAS_START, I_MEAS_STOP, O_RD_VALID, O_MEASURING,
	input wire logic [7:0] O_RD_DATA,
	input wire logic O_FAN_MAX, O_RESULT_HOLD, O_SOFT_RESET
);
	int unsigned cnt;
	wire go = I_PTR_STROBE && I_PTR_NODATA;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// fan high cycles, since a property repeat cannot hold the real count
	always_ff @(posedge I_CLK or negedge I_RST_N)
		if (!I_RST_N)
			cnt <= 0;
		else
			cnt <= O_FAN_MAX ? cnt + 1 : 0;
	AST_CLN_GO: assert property (go && I_PTR == 16'h5607 && O_MEASURING
		&& !O_FAN_MAX && !I_MEAS_STOP |=> O_FAN_MAX) else $error("no clean");
	AST_CLN_MEAS: assert property (!O_MEASURING |=> !O_FAN_MAX) else $error("idle clean");
	AST_CLN_LEN: assert property ($fell(O_FAN_MAX) && O_MEASURING
		|-> $past(cnt) == CLEAN_CYCLES - 1) else $error("clean short");
	AST_CLN_MAX: assert property (O_FAN_MAX |-> cnt < CLEAN_CYCLES) else $error("long");
	AST_HOLD: assert property (O_RESULT_HOLD == O_FAN_MAX) else $error("hold");
	AST_SRST: assert property (go && I_PTR == 16'hD304 |=> O_SOFT_RESET
		&& !O_MEASURING && !O_FAN_MAX && O_RD_DATA == 8'h00) else $error("srst");
	AST_SRST_SRC: assert property (O_SOFT_RESET |-> $past(go && I_PTR == 16'hD304))
		else $error("stray srst");
	AST_RD: assert property (O_RD_VALID == $past(I_RD_REQ && !I_PTR_STROBE))
		else $error("rd valid");
	AST_STOP: assert property (I_MEAS_STOP && O_MEASURING |=> !O_MEASURING && !O_FAN_MAX)
		else $error("stop");
	cover property ($fell(O_FAN_MAX) && !O_MEASURING);
	cover property ($rose(O_FAN_MAX));
	cover property (O_SOFT_RESET);
	cover property (O_RD_VALID);
endmodule
bind smc_cmd smc_cmd_assertions #(.CLEAN_CYCLES(CLEAN_CYCLES)) u_chk (.I_CLK, .I_RST_N,
	.I_PTR_STROBE, .I_PTR_NODATA, .I_RD_REQ, .I_PTR, .I_MEAS_START, .I_MEAS_STOP, .O_RD_VALID,
	.O_MEASURING, .O_RD_DATA, .O_FAN_MAX, .O_RESULT_HOLD, .O_SOFT_RESET);

// ===== dv/tb.sv
// self-checking bench for smc_cmd
// assumes the host model makes all pointer and read traffic
`timescale 1ns/100ps
module tb;
	import smc_pkg::*;
	localparam int N = 20;
	localparam logic [STR_BITS-1:0] SER = {32{8'h41}};
	logic I_CLK = 0, I_RST_N = 0, I_MEAS_START = 0, I_MEAS_STOP = 0;
	logic stb, nd, req, vld, fan, hold, meas, srst;
	logic [15:0] ptr;
	logic [7:0] rdd;
	int n_fail = 0, checks = 0;
	smc_host host (.i_clk(I_CLK), .i_vld(vld), .i_data(rdd), .o_stb(stb), .o_nd(nd),
		.o_req(req), .o_ptr(ptr));
	smc_cmd #(.CLEAN_CYCLES(N), .SERIAL(SER)) dut (.I_CLK, .I_RST_N, .I_PTR_STROBE(stb),
		.I_PTR(ptr), .I_PTR_NODATA(nd), .I_RD_REQ(req), .O_RD_VALID(vld), .O_RD_DATA(rdd),
		.I_MEAS_START, .I_MEAS_STOP, .O_MEASURING(meas), .O_FAN_MAX(fan),
		.O_RESULT_HOLD(hold), .O_SOFT_RESET(srst));
	initial forever #20 I_CLK = ~I_CLK;
	task chk(input logic [7:0] g, e);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [7:0] crc(input logic [15:0] d);
		logic [7:0] c = 8'hFF;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
		return c;
	endfunction
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// reads one past the end, which must answer zero
	task t_str(input logic [15:0] p, input logic [STR_BITS-1:0] s);
		logic [7:0] b, e, c0, c1;
		logic v;
		host.set_ptr(p, 0);
		for (int i = 0; i < 49; i++)
		begin
			c0 = s[255 - 16 * (i / 3) -: 8];
			c1 = (i / 3 == 15) ? 8'h00 : s[247 - 16 * (i / 3) -: 8];
			e = (i > 47) ? 8'h00 : (i % 3 == 0) ? c0 : (i % 3 == 1) ? c1 : crc({c0, c1});
			host.rd(b, v);
			chk(v, 1);
			chk(b, e);
		end
		$display("string test done");
	endtask
	task t_clean;
		int n;
		n = 0;
		host.set_ptr(PTR_FAN_CLEAN, 1);
		chk(fan, 0);
		@(negedge I_CLK);
		I_MEAS_START = 1;
		@(negedge I_CLK);
		I_MEAS_START = 0;
		host.set_ptr(PTR_FAN_CLEAN, 0);
		chk(fan, 0);
		host.set_ptr(PTR_FAN_CLEAN, 1);
		while (fan === 1 && n < 99)
		begin
			chk(hold, 1);
			n++;
			@(negedge I_CLK);
		end
		chk(8'(n), 8'(N));
		chk(meas, 1);
		chk(hold, 0);
		$display("clean test done");
	endtask
	task t_reset;
		logic [7:0] b;
		logic v;
		host.set_ptr(PTR_ART_CODE, 0);
		host.rd(b, v);
		host.set_ptr(PTR_FAN_CLEAN, 1);
		host.set_ptr(PTR_SOFT_RESET, 0);
		chk(fan, 1);
		host.set_ptr(PTR_SOFT_RESET, 1);
		chk(srst, 1);
		chk(fan, 0);
		chk(rdd, 0);
		chk(meas, 0);
		host.rd(b, v);
		chk(v, 1);
		chk(b, 0);
		$display("reset test done");
	endtask
	// stop while cleaning aborts it; a clean request in idle is then ignored
	task t_stop;
		@(negedge I_CLK);
		I_MEAS_START = 1;
		@(negedge I_CLK);
		I_MEAS_START = 0;
		host.set_ptr(PTR_FAN_CLEAN, 1);
		chk(fan, 1);
		I_MEAS_STOP = 1;
		@(negedge I_CLK);
		I_MEAS_STOP = 0;
		chk(fan, 0);
		chk(hold, 0);
		chk(meas, 0);
		host.set_ptr(PTR_FAN_CLEAN, 1);
		chk(fan, 0);
		$display("stop test done");
	endtask
	initial
	begin
		repeat (8) @(negedge I_CLK);
		I_RST_N = 1;
		t_str(PTR_ART_CODE, ART_CODE_DFLT);
		t_str(PTR_SERIAL, SER);
		t_clean;
		t_reset;
		t_stop;
		give_verdict;
	end
	// run needs about 255 cycles; allow over fifteen times that
	initial
	begin
		#160000;
		n_fail++;
		give_verdict;
	end
endmodule
